// file: inc/dcc_defs.vh
// Register offsets, field positions and reset values for the calibration register bank.
`ifndef DCC_DEFS_VH
`define DCC_DEFS_VH
`define DCC_IDX_PWRCFG 4'h7
`define DCC_IDX_CALEN 4'h8
`define DCC_IDX_GAIN 4'h9
`define DCC_IDX_OFFS 4'hA
`define DCC_IDX_STAT 4'hB
`define DCC_IDX_CODE 4'hE
`define DCC_IDX_MODE 4'hF
`define DCC_RST_ZERO 16'h0000
`define DCC_RST_STAT 16'h1000
`define DCC_ARM_LSB 0
`define DCC_ARM_MSB 1
`define DCC_NCL_LSB 2
`define DCC_NCL_MSB 5
`define DCC_NCL_RST 4'h0
`define DCC_NCL_MAXCUR 4'h9
`define DCC_NCL_V9 4'h2
`define DCC_NCL_V15 4'h7
`define DCC_NCL_V18 4'h9
`define DCC_ARM_POS 2'h1
`define DCC_ARM_NEG 2'h2
`define DCC_CALEN_BIT 0
`define DCC_GAIN_ONE 17'h10000
`define DCC_IDX_LSB 2
`define DCC_IDX_MSB 5
`define DCC_ALIGN_MSB 1
`define DCC_ADDR_MSB 31
`define DCC_WORD_MSB 15
`define DCC_VMODE_BIT 0
`define DCC_PROD_MSB 32
`define DCC_PROD_LSB 16
`define DCC_CODE_MAX 16'hFFFF
`define DCC_CODE_MIN 16'h0000
`endif

// file: src/dcc_cal_regs.v
// APB register bank with clamp select, arm enable and output code calibration.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "dcc_defs.vh"

module dcc_cal_regs (
    input wire mclk, // 40 MHz clock
    input wire rst, // synchronous reset, active high
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [31:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output wire pready, // APB ready
    output reg [31:0] prdata, // APB read data
    output wire pslverr, // APB error on unmapped address
    output wire [3:0] negativeArmClampSelect, // negative clamp code
    output wire clampCodeInvalid, // clamp code not valid in current mode
    output wire posArmEnable, // positive converter arm on
    output wire negArmEnable, // negative converter arm on
    output reg [15:0] converterCode // code sent to the converter
);

    ////////////////////////////////////////////////////////////////////////////
    // Register state and the next value of each register.

    reg [15:0] pwrCfg_q;
    reg [15:0] pwrCfg_d;
    reg [15:0] calEn_q;
    reg [15:0] calEn_d;
    reg [15:0] gain_q;
    reg [15:0] gain_d;
    reg [15:0] offs_q;
    reg [15:0] offs_d;
    reg [15:0] stat_q;
    reg [15:0] stat_d;
    reg [15:0] code_q;
    reg [15:0] code_d;
    reg voltMode_q;
    reg voltMode_d;
    reg clampBad_q;
    reg clampBad_d;
    reg [31:0] rdata_d;
    reg [15:0] outCode_d;
    reg [15:0] calCode;
    reg [15:0] rdWord;
    reg mapped;

    wire [3:0] idx;
    wire accessPhase;
    wire setupRead;
    wire wrStrobe;
    wire wrPwrCfg;
    wire wrCalEn;
    wire wrGain;
    wire wrOffs;
    wire wrStat;
    wire wrCode;
    wire wrMode;

    ////////////////////////////////////////////////////////////////////////////
    // Only aligned words inside the bank window are accepted; the rest is an error.

    function addrInBank;
        input [31:0] addr;
        begin
            addrInBank = ~|addr[`DCC_ADDR_MSB:`DCC_IDX_MSB + 1] &&
                ~|addr[`DCC_ALIGN_MSB:0];
        end
    endfunction

    function regExists;
        input [3:0] sel;
        begin
            case (sel)
                `DCC_IDX_PWRCFG: begin
                    regExists = 1'b1;
                end
                `DCC_IDX_CALEN: begin
                    regExists = 1'b1;
                end
                `DCC_IDX_GAIN: begin
                    regExists = 1'b1;
                end
                `DCC_IDX_OFFS: begin
                    regExists = 1'b1;
                end
                `DCC_IDX_STAT: begin
                    regExists = 1'b1;
                end
                `DCC_IDX_CODE: begin
                    regExists = 1'b1;
                end
                `DCC_IDX_MODE: begin
                    regExists = 1'b1;
                end
                default: begin
                    regExists = 1'b0;
                end
            endcase
        end
    endfunction

    function writeHit;
        input strobe;
        input [3:0] sel;
        input [3:0] want;
        begin
            writeHit = strobe && (sel == want);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // The flag is only advice: the field keeps whatever software writes.

    function clampInvalid;
        input [3:0] code;
        input volt;
        begin
            if (volt) begin
                clampInvalid = !(code == `DCC_NCL_V9 || code == `DCC_NCL_V15 ||
                    code == `DCC_NCL_V18);
            end else begin
                clampInvalid = (code > `DCC_NCL_MAXCUR);
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Gain is read as a fraction of full scale plus one, so a zero word is unity.
    // The sum saturates rather than wraps, since a wrapped code would swing rails.

    function [15:0] calApply;
        input [15:0] code;
        input [15:0] gain;
        input [15:0] offs;
        reg [32:0] prod;
        reg [18:0] sum;
        begin
            prod = code * (`DCC_GAIN_ONE + {1'b0, gain});
            sum = {2'b00, prod[`DCC_PROD_MSB:`DCC_PROD_LSB]} + {{3{offs[15]}}, offs};
            if (sum[18] == 1'b1) begin
                calApply = `DCC_CODE_MIN;
            end else if (sum[17:16] != 2'b00) begin
                calApply = `DCC_CODE_MAX;
            end else begin
                calApply = sum[15:0];
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode. Read data is fetched in the setup cycle, so it already stands
    // when the zero-wait access phase completes; this keeps pready tied high.

    assign idx = paddr[`DCC_IDX_MSB:`DCC_IDX_LSB];
    assign accessPhase = psel & penable;
    assign setupRead = psel & ~penable & ~pwrite;
    assign wrStrobe = accessPhase & pwrite & mapped;
    assign pready = 1'b1;
    assign pslverr = accessPhase & ~mapped;

    assign wrPwrCfg = writeHit(wrStrobe, idx, `DCC_IDX_PWRCFG);
    assign wrCalEn = writeHit(wrStrobe, idx, `DCC_IDX_CALEN);
    assign wrGain = writeHit(wrStrobe, idx, `DCC_IDX_GAIN);
    assign wrOffs = writeHit(wrStrobe, idx, `DCC_IDX_OFFS);
    assign wrStat = writeHit(wrStrobe, idx, `DCC_IDX_STAT);
    assign wrCode = writeHit(wrStrobe, idx, `DCC_IDX_CODE);
    assign wrMode = writeHit(wrStrobe, idx, `DCC_IDX_MODE);

    always @* begin
        mapped = addrInBank(paddr) && regExists(idx);
    end

    always @* begin
        rdWord = `DCC_RST_ZERO;
        case (idx)
            `DCC_IDX_PWRCFG: begin
                rdWord = pwrCfg_q;
            end
            `DCC_IDX_CALEN: begin
                rdWord = calEn_q;
            end
            `DCC_IDX_GAIN: begin
                rdWord = gain_q;
            end
            `DCC_IDX_OFFS: begin
                rdWord = offs_q;
            end
            `DCC_IDX_STAT: begin
                rdWord = stat_q;
            end
            `DCC_IDX_CODE: begin
                rdWord = code_q;
            end
            `DCC_IDX_MODE: begin
                rdWord = {15'h0000, voltMode_q};
            end
            default: begin
                rdWord = `DCC_RST_ZERO;
            end
        endcase
    end

    always @* begin
        rdata_d = prdata;
        if (setupRead && mapped) begin
            rdata_d = {`DCC_RST_ZERO, rdWord};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next values of the storage registers.

    always @* begin
        pwrCfg_d = wrPwrCfg ? pwdata[`DCC_WORD_MSB:0] : pwrCfg_q;
        calEn_d = wrCalEn ? pwdata[`DCC_WORD_MSB:0] : calEn_q;
        gain_d = wrGain ? pwdata[`DCC_WORD_MSB:0] : gain_q;
        offs_d = wrOffs ? pwdata[`DCC_WORD_MSB:0] : offs_q;
        stat_d = wrStat ? pwdata[`DCC_WORD_MSB:0] : stat_q;
        code_d = wrCode ? pwdata[`DCC_WORD_MSB:0] : code_q;
        voltMode_d = wrMode ? pwdata[`DCC_VMODE_BIT] : voltMode_q;
        clampBad_d = clampInvalid(pwrCfg_d[`DCC_NCL_MSB:`DCC_NCL_LSB], voltMode_d);
    end

    always @(posedge mclk) begin
        if (rst) begin
            pwrCfg_q <= `DCC_RST_ZERO;
            calEn_q <= `DCC_RST_ZERO;
            gain_q <= `DCC_RST_ZERO;
            offs_q <= `DCC_RST_ZERO;
            stat_q <= `DCC_RST_STAT;
            code_q <= `DCC_RST_ZERO;
            voltMode_q <= 1'b0;
            clampBad_q <= 1'b0;
        end else begin
            pwrCfg_q <= pwrCfg_d;
            calEn_q <= calEn_d;
            gain_q <= gain_d;
            offs_q <= offs_d;
            stat_q <= stat_d;
            code_q <= code_d;
            voltMode_q <= voltMode_d;
            clampBad_q <= clampBad_d;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            prdata <= {`DCC_RST_ZERO, `DCC_RST_ZERO};
        end else begin
            prdata <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clamp select and arm outputs come straight from the configuration flip-flops; the clamp flag comes from its own flip-flop.

    assign negativeArmClampSelect = pwrCfg_q[`DCC_NCL_MSB:`DCC_NCL_LSB];
    assign clampCodeInvalid = clampBad_q;
    assign posArmEnable = pwrCfg_q[`DCC_ARM_LSB];
    assign negArmEnable = pwrCfg_q[`DCC_ARM_MSB];

    ////////////////////////////////////////////////////////////////////////////
    // Output code path. The extra register costs one cycle of latency but keeps
    // the long multiply off the converter pins.

    always @* begin
        calCode = calApply(code_q, gain_q, offs_q);
        outCode_d = code_q;
        if (calEn_q[`DCC_CALEN_BIT]) begin
            outCode_d = calCode;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            converterCode <= `DCC_RST_ZERO;
        end else begin
            converterCode <= outCode_d;
        end
    end

endmodule

// file: bench/dcc_cal_regs_properties.sv
// Port checks for the calibration register bank.
`timescale 1ns/1ps
module dcc_cal_regs_chk (
    input wire mclk, // clock
    input wire rst, // reset
    input wire psel, // bus select
    input wire penable, // bus enable
    input wire pwrite, // bus direction
    input wire pready, // bus ready
    input wire pslverr, // bus error
    input wire [31:0] paddr, // bus address
    input wire [31:0] pwdata, // bus write data
    input wire [31:0] prdata, // bus read data
    input wire [3:0] negativeArmClampSelect, // clamp
    input wire clampCodeInvalid, // clamp flag
    input wire posArmEnable, // positive arm
    input wire negArmEnable, // negative arm
    input wire [15:0] converterCode // output
);
reg cal_q;
reg volt_q;
wire acc = psel && penable;
wire [3:0] ncl = negativeArmClampSelect;
wire [1:0] arm = {negArmEnable, posArmEnable};
wire [15:0] wd = pwdata[15:0];
default clocking @(posedge mclk); endclocking
default disable iff (rst);
sequence wr(a);
    acc && pwrite && paddr == a;
endsequence
// Shadows of the enable and mode bits, which the ports do not show.
always @(posedge mclk) begin
    cal_q <= rst ? 1'h0 : acc && pwrite && paddr == 32'h20 ? pwdata[0] : cal_q;
    volt_q <= rst ? 1'h0 : acc && pwrite && paddr == 32'h3C ? pwdata[0] : volt_q;
end
a_clamp_store: assert property (wr(32'h1C) |=> ncl == $past(pwdata[5:2]))
    else $error("clamp");
a_arm_store: assert property (wr(32'h1C) |=> arm == $past(pwdata[1:0]))
    else $error("arms");
a_clamp_bad: assert property (
    clampCodeInvalid == (volt_q ? !(ncl inside {4'h2, 4'h7, 4'h9}) : ncl > 4'h9))
    else $error("validity");
a_code_pass: assert property (wr(32'h38) ##0 !cal_q |-> ##2 converterCode == $past(wd, 2))
    else $error("pass");
a_gain_ignored: assert property (wr(32'h24) ##0 !cal_q |=> $stable(converterCode))
    else $error("gain");
a_offs_ignored: assert property (wr(32'h28) ##0 !cal_q |=> $stable(converterCode))
    else $error("offset");
a_cal_mapped: assert property (acc && paddr[31:4] == 28'h2 && !paddr[1:0] |-> !pslverr)
    else $error("map");
a_read_upper: assert property (acc && !pwrite && pready |-> prdata[31:16] == 16'h0000)
    else $error("upper");
endmodule
bind dcc_cal_regs dcc_cal_regs_chk u_chk (
    .mclk(mclk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pready(pready),
    .pslverr(pslverr),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .negativeArmClampSelect(negativeArmClampSelect),
    .clampCodeInvalid(clampCodeInvalid),
    .posArmEnable(posArmEnable),
    .negArmEnable(negArmEnable),
    .converterCode(converterCode)
);

// file: bench/dcc_cal_regs_tb.sv
// Self-checking bench for the calibration register bank.
`timescale 1ns/1ps
module dcc_cal_regs_tb;
reg mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err = 0;
reg [31:0] paddr = 0, pwdata = 0;
reg [31:0] rdq = 0;
wire pready, pslverr, clampCodeInvalid, posArmEnable, negArmEnable;
wire [31:0] prdata;
wire [3:0] negativeArmClampSelect;
wire [15:0] converterCode;
integer mismatches = 0, n_compared = 0, i, j;
dcc_cal_regs dut (
    .mclk(mclk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .negativeArmClampSelect(negativeArmClampSelect),
    .clampCodeInvalid(clampCodeInvalid),
    .posArmEnable(posArmEnable),
    .negArmEnable(negArmEnable),
    .converterCode(converterCode)
);
initial forever #12.5 mclk = ~mclk;
task wrap_up;
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
endtask
task cmp(input [31:0] e, input [31:0] g);
    n_compared = n_compared + 1;
    if (g !== e) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED %0t %h %h", $time, e, g);
    end
endtask
// The two extra edges at the end let registered outputs settle before sampling.
task apb(input w, input [31:0] a, input [31:0] d);
    integer n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
        @(posedge mclk);
        n = n + 1;
    end while (pready !== 1'h1 && n < 20);
    // Read data and the error flag are taken at the edge that completes the access.
    rdq = prdata;
    err = pslverr;
    if (pready !== 1'h1) begin
        mismatches = mismatches + 1;
        wrap_up;
    end else begin
        psel <= 1'h0;
        penable <= 1'h0;
        repeat (2) @(posedge mclk);
    end
endtask
task t_regs;
    cmp(0, {negativeArmClampSelect, negArmEnable, posArmEnable});
    for (i = 8; i < 12; i = i + 1) begin
        apb(0, i * 4, 0);
        cmp(i == 11 ? 32'h1000 : 32'h0, rdq);
        apb(1, i * 4, 32'hA5C0 + i);
        apb(0, i * 4, 0);
        cmp(32'hA5C0 + i, rdq);
    end
    apb(0, 32'h40, 0);
    cmp(1, err);
endtask
task t_clamp;
    for (j = 0; j < 2; j = j + 1) begin
        apb(1, 32'h3C, j);
        for (i = 0; i < 16; i = i + 1) begin
            apb(1, 32'h1C, i * 4 + i % 4);
            cmp(j ? !(i == 2 || i == 7 || i == 9) : i > 9, clampCodeInvalid);
            cmp(i * 4 + i % 4, {negativeArmClampSelect, negArmEnable, posArmEnable});
        end
    end
endtask
task t_cal;
    apb(1, 32'h24, 32'h8000);
    apb(1, 32'h28, 32'h10);
    apb(1, 32'h38, 32'h1234);
    cmp(32'h1234, converterCode);
    apb(1, 32'h20, 1);
    cmp(32'h1B5E, converterCode);
endtask
// A reset in mid-run must bring back the reset values of the clamp, arm, status and enable fields and of the output code.
task t_reset;
    apb(1, 32'h1C, 32'h3F);
    apb(1, 32'h2C, 32'h0);
    rst <= 1'h1;
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    cmp(0, {negativeArmClampSelect, negArmEnable, posArmEnable});
    cmp(0, converterCode);
    apb(0, 32'h2C, 0);
    cmp(32'h1000, rdq);
    apb(0, 32'h20, 0);
    cmp(0, rdq);
endtask
initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    t_regs;
    t_clamp;
    t_cal;
    t_reset;
    wrap_up;
end
endmodule
